// ---- core/ccst_device.sv ----
// converter end: clock source detection, state timing and serial output
`timescale 1ns/1ps
`include "ccst_params.svh"
module ccst_device #(
  parameter int CONV_60_CYC = `CCST_CONV_60_US * (`CCST_CLK_HZ / 1000000),
  parameter int CONV_50_CYC = `CCST_CONV_50_US * (`CCST_CLK_HZ / 1000000),
  parameter int SCK_HALF_CYC = (`CCST_READ_INT_US * (`CCST_CLK_HZ / 1000000))
                               / (`CCST_WORD_BITS * 2),
  parameter int EXT_WIN_CYC = `CCST_CLK_HZ / `CCST_EXT_MIN_HZ
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  ccst_if.device                      link,
  input  wire logic [29:0]            sample,
  output ccst_pkg::ccst_dev_state_t   state,
  output logic                        ext_clk_mode,
  output logic                        notch_50,
  output logic                        int_sck_mode
);
  import ccst_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0]  pin_raw;
  logic [2:0]  pin_meta;
  logic [2:0]  pin_sync;
  logic [2:0]  pin_dly;

  assign pin_raw = {link.rejection_select_pin, link.cs_b, link.sck};

  // reset to each pin's idle level: select rests low while the master is in reset,
  // chip select and the pulled-up clock rest high, so no false edge follows reset
  localparam logic [2:0] PIN_IDLE = 3'h3;

  // two stages before use, a third stage only for edge detection
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          pin_meta[gi] <= PIN_IDLE[gi];
          pin_sync[gi] <= PIN_IDLE[gi];
          pin_dly[gi]  <= PIN_IDLE[gi];
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
          pin_dly[gi]  <= pin_sync[gi];
        end
      end
    end
  endgenerate

  logic        sel_s;
  logic        cs_s;
  logic        sck_s;
  logic        sel_rise;
  logic        cs_fall;
  logic        cs_rise;
  logic        xsck_rise;
  logic        xsck_fall;

  assign sel_s     = pin_sync[2];
  assign cs_s      = pin_sync[1];
  assign sck_s     = pin_sync[0];
  assign sel_rise  = pin_sync[2] & ~pin_dly[2];
  assign cs_fall   = ~pin_sync[1] & pin_dly[1];
  assign cs_rise   = pin_sync[1] & ~pin_dly[1];
  assign xsck_rise = pin_sync[0] & ~pin_dly[0];
  assign xsck_fall = ~pin_sync[0] & pin_dly[0];

  // ****************************************************************
  // conversion clock source
  // ****************************************************************
  logic [16:0] det_cnt;

  // cycles since the last rising select edge; saturates at the detection window
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      det_cnt <= 17'h1FFFF;
    end else if (sel_rise) begin
      det_cnt <= 17'h00000;
    end else if (det_cnt < 17'(EXT_WIN_CYC)) begin
      det_cnt <= det_cnt + 17'h00001;
    end
  end

  // two rising edges closer than one period of the slowest legal clock mean a
  // clock; rise to rise keeps the duty cycle out of it, a level change never counts
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_clk_mode <= 1'b0;
    end else if (sel_rise && det_cnt < 17'(EXT_WIN_CYC)) begin
      ext_clk_mode <= 1'b1;
    end else if (det_cnt >= 17'(EXT_WIN_CYC)) begin
      ext_clk_mode <= 1'b0;
    end
  end

  // notch follows the select level only while the oscillator is in charge;
  // a rise may be a clock's first edge, so it waits out one window
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      notch_50 <= 1'b0;
    end else if (!ext_clk_mode && det_cnt >= 17'(EXT_WIN_CYC)) begin
      notch_50 <= sel_s;
    end
  end

  // one conversion clock period: each system cycle for the oscillator,
  // each rising select edge for an external clock
  logic        conv_tick;
  assign conv_tick = ext_clk_mode ? sel_rise : 1'b1;

  // ****************************************************************
  // convert timing
  // ****************************************************************
  logic [24:0] conv_cnt;
  logic [24:0] conv_lim;
  logic        conv_done;

  // limit is looked up live, so a mid-conversion change only skews this one
  always_comb begin
    if (ext_clk_mode) begin
      conv_lim = 25'(`CCST_EXT_CONV_PERIODS - 1);
    end else if (notch_50) begin
      conv_lim = 25'(CONV_50_CYC - 1);
    end else begin
      conv_lim = 25'(CONV_60_CYC - 1);
    end
  end

  assign conv_done = (state == CCST_CONVERT) && conv_tick && (conv_cnt >= conv_lim);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      conv_cnt <= 25'h0000000;
    end else if (state != CCST_CONVERT || conv_done) begin
      conv_cnt <= 25'h0000000;
    end else if (conv_tick) begin
      conv_cnt <= conv_cnt + 25'h0000001;
    end
  end

  // ****************************************************************
  // serial clock mode and internal serial clock
  // ****************************************************************
  // mode is taken at each chip select fall; a floating clock reads high
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      int_sck_mode <= 1'b1;
    end else if (cs_fall) begin
      int_sck_mode <= sck_s;
    end
  end

  logic        sck_drv;
  logic        int_run;
  logic [12:0] sck_div;
  logic [12:0] half_lim;
  logic        sck_tick;
  logic        sck_out;
  logic        sck_oe;

  // clock driven for the whole select window and held low outside readout, so no stray edge follows the
  // last bit; the select-fall cycle is skipped while the mode is re-taken
  assign sck_drv  = int_sck_mode & ~cs_s & ~cs_fall;
  assign int_run  = sck_drv & (state != CCST_CONVERT);
  // half period: four conversion clock periods with an external clock (one serial clock is eight), SCK_HALF_CYC system cycles otherwise
  assign half_lim = ext_clk_mode ? 13'((`CCST_SCK_DIV / 2) - 1)
                                 : 13'(SCK_HALF_CYC - 1);
  assign sck_tick = int_run & conv_tick & (sck_div >= half_lim);

  // a source switch only moves the next toggle, so duty changes, data holds
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sck_div <= 13'h0000;
    end else if (!int_run || sck_tick) begin
      sck_div <= 13'h0000;
    end else if (conv_tick) begin
      sck_div <= sck_div + 13'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sck_out <= 1'b0;
      sck_oe  <= 1'b0;
    end else begin
      sck_out <= int_run ? (sck_out ^ sck_tick) : 1'b0;
      sck_oe  <= sck_drv;
    end
  end

  logic        ser_rise;
  logic        ser_fall;

  assign ser_rise = ~cs_s & (int_sck_mode ? (sck_tick & ~sck_out) : xsck_rise);
  assign ser_fall = ~cs_s & (int_sck_mode ? (sck_tick & sck_out) : xsck_fall);

  // ****************************************************************
  // state machine and output word
  // ****************************************************************
  logic [4:0]  bit_cnt;
  logic [31:0] shreg;
  logic        sdo_oe;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= CCST_CONVERT;
    end else begin
      unique case (state)
        CCST_CONVERT: begin
          if (conv_done) begin
            state <= CCST_SLEEP;
          end
        end
        CCST_SLEEP: begin
          if (ser_rise) begin
            state <= CCST_OUTPUT;
          end
        end
        CCST_OUTPUT: begin
          if (cs_rise) begin
            state <= CCST_CONVERT;
          end else if (ser_fall && bit_cnt == 5'h1F) begin
            state <= CCST_CONVERT;
          end
        end
      endcase
    end
  end

  // falling edges counted through the readout
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt <= 5'h00;
    end else if (state != CCST_OUTPUT) begin
      bit_cnt <= 5'h00;
    end else if (ser_fall) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // all ones outside sleep and readout, so the line shows busy while converting
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shreg <= 32'hFFFFFFFF;
    end else if (conv_done) begin
      shreg <= {2'b00, sample};
    end else if (state == CCST_OUTPUT && (cs_rise || (ser_fall && bit_cnt == 5'h1F))) begin
      shreg <= 32'hFFFFFFFF;
    end else if (state == CCST_OUTPUT && ser_fall) begin
      shreg <= {shreg[30:0], 1'b1};
    end
  end

  // data line is released while chip select is high
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= ~cs_s;
    end
  end

  assign link.sdo_o      = shreg[31];
  assign link.sdo_oe     = sdo_oe;
  assign link.sck_dev_o  = sck_out;
  assign link.sck_dev_oe = sck_oe;
endmodule

// ---- core/ccst_params.svh ----
// constants for the conversion-clock select and state timing block
// ****************************************************************
// ****************************************************************
`ifndef CCST_PARAMS_SVH
`define CCST_PARAMS_SVH

`define CCST_CLK_HZ            250000000
`define CCST_CONV_60_US        66600
`define CCST_CONV_50_US        80000
`define CCST_READ_INT_US       1670
`define CCST_EXT_MIN_HZ        2560
`define CCST_EXT_CONV_PERIODS  10278
`define CCST_READ_EXT_PERIODS  256
`define CCST_SCK_DIV           8
`define CCST_WORD_BITS         32
`define CCST_MST_SCK_HALF_CYC  16

`endif

// ---- core/ccst_pkg.sv ----
// types shared by both ends of the converter link
package ccst_pkg;
  typedef enum logic [2:0] {
    CCST_CONVERT = 3'h1,
    CCST_SLEEP   = 3'h2,
    CCST_OUTPUT  = 3'h4
  } ccst_dev_state_t;

  typedef enum logic [3:0] {
    CCST_M_IDLE   = 4'h1,
    CCST_M_SELECT = 4'h2,
    CCST_M_WAIT   = 4'h4,
    CCST_M_SHIFT  = 4'h8
  } ccst_mst_state_t;
endpackage

// ---- core/ccst_if.sv ----
// interface joining the converter end and the serial master end
`timescale 1ns/1ps
interface ccst_if;
  logic rejection_select_pin;
  logic cs_b;
  logic sck_dev_o;
  logic sck_dev_oe;
  logic sck_mst_o;
  logic sck_mst_oe;
  logic sdo_o;
  logic sdo_oe;
  logic sck;
  logic sdo;

  // an undriven serial clock floats high, which selects internal clock mode
  assign sck = sck_dev_oe ? sck_dev_o : (sck_mst_oe ? sck_mst_o : 1'b1);
  assign sdo = sdo_oe ? sdo_o : 1'b1;

  modport device (
    input  rejection_select_pin,
    input  cs_b,
    input  sck,
    output sck_dev_o,
    output sck_dev_oe,
    output sdo_o,
    output sdo_oe
  );

  modport master (
    output rejection_select_pin,
    output cs_b,
    output sck_mst_o,
    output sck_mst_oe,
    input  sck,
    input  sdo
  );
endinterface

// ---- core/ccst_master.sv ----
// serial master end: select pin drive, readout and running average
`timescale 1ns/1ps
`include "ccst_params.svh"
module ccst_master (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  ccst_if.master                      link,
  input  wire logic                   sel_level,
  input  wire logic                   osc_en,
  input  wire logic [15:0]            osc_half,
  input  wire logic                   start,
  input  wire logic                   ext_sck,
  output logic                        busy,
  output logic [31:0]                 rd_word,
  output logic                        rd_valid,
  output logic [29:0]                 avg_result
);
  import ccst_pkg::*;

  // ****************************************************************
  // select pin: level or conversion clock
  // ****************************************************************
  logic [15:0] osc_cnt;
  logic        sel_pin;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osc_cnt <= 16'h0000;
      sel_pin <= 1'b0;
    end else if (!osc_en) begin
      osc_cnt <= 16'h0000;
      sel_pin <= sel_level; // hold the level: low selects CONV_60_CYC timing, high CONV_50_CYC
    end else if (osc_cnt + 16'h0001 >= osc_half) begin
      osc_cnt <= 16'h0000;
      sel_pin <= ~sel_pin; // caller keeps the rate at or above the minimum
    end else begin
      osc_cnt <= osc_cnt + 16'h0001;
    end
  end

  // ****************************************************************
  // synchronisers for the returning lines
  // ****************************************************************
  logic [1:0]  in_raw;
  logic [1:0]  in_meta;
  logic [1:0]  in_sync;
  logic        sck_dly;

  assign in_raw = {link.sdo, link.sck};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          in_meta[gi] <= 1'b1;
          in_sync[gi] <= 1'b1;
        end else begin
          in_meta[gi] <= in_raw[gi];
          in_sync[gi] <= in_meta[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sck_dly <= 1'b1;
    end else begin
      sck_dly <= in_sync[0];
    end
  end

  logic        s_rise;
  logic        s_fall;
  assign s_rise = in_sync[0] & ~sck_dly;
  assign s_fall = ~in_sync[0] & sck_dly;

  // ****************************************************************
  // readout sequence
  // ****************************************************************
  ccst_mst_state_t mstate;
  logic        cs_b;
  logic        sck_o;
  logic        sck_oe;
  logic [7:0]  half_cnt;
  logic [5:0]  nbits;
  logic [31:0] shin;
  logic [29:0] prev;
  logic [30:0] pair_sum;

  assign pair_sum = {1'b0, prev} + {1'b0, shin[29:0]};

  // clock generated only in external mode; sampled on the returned edges
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mstate   <= CCST_M_IDLE;
      cs_b     <= 1'b1;
      sck_o    <= 1'b0;
      sck_oe   <= 1'b0;
      half_cnt <= 8'h00;
      nbits    <= 6'h00;
      shin     <= 32'h00000000;
    end else begin
      unique case (mstate)
        CCST_M_IDLE: begin
          if (start) begin
            sck_o  <= 1'b0;
            sck_oe <= ext_sck;
            mstate <= CCST_M_SELECT;
          end
        end
        CCST_M_SELECT: begin
          cs_b   <= 1'b0;
          mstate <= CCST_M_WAIT;
        end
        CCST_M_WAIT: begin
          half_cnt <= 8'h00;
          nbits    <= 6'h00;
          if (!in_sync[1]) begin
            mstate <= CCST_M_SHIFT; // status low means result ready
          end
        end
        CCST_M_SHIFT: begin
          // the 32nd rise is counted before its fall, so run until the line is low
          if (sck_oe && !(nbits == 6'h20 && !sck_o)) begin
            if (half_cnt == 8'(`CCST_MST_SCK_HALF_CYC - 1)) begin
              half_cnt <= 8'h00;
              sck_o    <= ~sck_o;
            end else begin
              half_cnt <= half_cnt + 8'h01;
            end
          end
          if (s_rise) begin
            shin  <= {shin[30:0], in_sync[1]};
            nbits <= nbits + 6'h01;
          end
          if (s_fall && nbits == 6'h20) begin
            cs_b   <= 1'b1;
            sck_oe <= 1'b0;
            mstate <= CCST_M_IDLE;
          end
        end
      endcase
    end
  end

  // result and running average of the last two
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_word    <= 32'h00000000;
      rd_valid   <= 1'b0;
      prev       <= 30'h00000000;
      avg_result <= 30'h00000000;
    end else begin
      rd_valid <= 1'b0;
      if (mstate == CCST_M_SHIFT && s_fall && nbits == 6'h20) begin
        rd_word    <= shin;
        rd_valid   <= 1'b1;
        prev       <= shin[29:0];
        avg_result <= pair_sum[30:1];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else begin
      busy <= (mstate != CCST_M_IDLE) || start;
    end
  end

  assign link.rejection_select_pin = sel_pin;
  assign link.cs_b                 = cs_b;
  assign link.sck_mst_o            = sck_o;
  assign link.sck_mst_oe           = sck_oe;
endmodule

// ---- verification/ccst_assertions.sv ----
// checker watching the serial link between the converter and the master
`timescale 1ns/1ps
module ccst_assertions (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic rejection_select_pin,
  input wire logic cs_b,
  input wire logic sck_dev_o,
  input wire logic sck_dev_oe,
  input wire logic sck_mst_o,
  input wire logic sck_mst_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sck,
  input wire logic sdo
);
  // *********************************
  // rising serial edges within one select
  // *********************************
  logic [5:0] rise_cnt;

  // counts on the resolved wire, so both clock sources are judged alike
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rise_cnt <= 6'h00;
    end else if (cs_b) begin
      rise_cnt <= 6'h00;
    end else if ($rose(sck)) begin
      rise_cnt <= rise_cnt + 6'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_shift_start;
    !cs_b && $rose(sck) && (rise_cnt == 6'h00);
  endsequence
  sequence s_last_fall;
    !cs_b && $fell(sck) && (rise_cnt == 6'h20);
  endsequence
  sequence s_cs_release;
    $rose(cs_b);
  endsequence

  // pin synchronisers give a few cycles of slack on each hop
  AST_SDO_ON: assert property ($fell(cs_b) |-> ##[1:6] sdo_oe)
    else $error("data line not driven after select");
  AST_LINK_OFF: assert property (s_cs_release |-> ##[1:6] (!sdo_oe && !sck_dev_oe))
    else $error("link still driven after deselect");
  AST_LINK_IDLE: assert property (cs_b [*8] |-> (!sdo_oe && !sck_dev_oe))
    else $error("link driven while deselected");
  AST_NO_FIGHT: assert property (!(sck_dev_oe && sck_mst_oe && (sck_dev_o != sck_mst_o)))
    else $error("both ends drive the serial clock");
  AST_DEV_SCK_CS: assert property ($rose(sck_dev_oe) |-> (!cs_b && !$past(cs_b, 2)))
    else $error("device clock started without select");
  AST_EOC_FIRST: assert property (s_shift_start |-> !sdo)
    else $error("shift began before conversion end");
  AST_RISE_MAX: assert property (rise_cnt <= 6'h20)
    else $error("more than 32 serial clocks in one readout");
  AST_NEW_CONV: assert property (s_last_fall |-> ##[1:8] sdo_o)
    else $error("no conversion flag after last bit");
  AST_FULL_WORD: assert property (s_cs_release |-> (rise_cnt == 6'h20))
    else $error("select released before a full word");
endmodule

// ---- verification/tb.sv ----
// self-checking bench: converter and master joined over the serial link
`timescale 1ns/1ps
module tb;
  import ccst_pkg::*;
  // shortened counts keep the run small; external conversions of 10278 edges are not run
  localparam int C60 = 400;
  localparam int C50 = 500;
  localparam int LIMIT = 60000;
  localparam logic [29:0] VA = 30'h2ABCDE01;
  localparam logic [29:0] VB = 30'h15A3C7F2;
  localparam logic [29:0] VC = 30'h3FFFFFFF;
  localparam logic [29:0] VD = 30'h00000001;
  localparam logic [29:0] VE = 30'h2468ACE0;
  localparam logic [29:0] VF = 30'h1B0D9C33;
  localparam logic [30:0] SUM = {1'b0, VA} + {1'b0, VB};

  logic            clk_sys;
  logic            rst_b;
  logic            sel_level;
  logic            osc_en;
  logic            start;
  logic            ext_sck;
  logic [15:0]     osc_half;
  logic [29:0]     sample;
  ccst_dev_state_t state;
  logic            ext_clk_mode;
  logic            notch_50;
  logic            int_sck_mode;
  logic            busy;
  logic            rd_valid;
  logic [31:0]     rd_word;
  logic [29:0]     avg_result;
  int              err_count = 0;
  int              samples_checked = 0;
  int              cyc = 0;
  int              conv_run = 0;

  ccst_if link ();
  ccst_device #(.CONV_60_CYC(C60), .CONV_50_CYC(C50), .SCK_HALF_CYC(20),
    .EXT_WIN_CYC(200)) ccst_device_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(link),
    .sample(sample), .state(state), .ext_clk_mode(ext_clk_mode), .notch_50(notch_50),
    .int_sck_mode(int_sck_mode));
  ccst_master ccst_master_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(link),
    .sel_level(sel_level), .osc_en(osc_en), .osc_half(osc_half), .start(start),
    .ext_sck(ext_sck), .busy(busy), .rd_word(rd_word), .rd_valid(rd_valid),
    .avg_result(avg_result));
  ccst_assertions ccst_assertions_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .rejection_select_pin(link.rejection_select_pin), .cs_b(link.cs_b),
    .sck_dev_o(link.sck_dev_o), .sck_dev_oe(link.sck_dev_oe), .sck_mst_o(link.sck_mst_o),
    .sck_mst_oe(link.sck_mst_oe), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe),
    .sck(link.sck), .sdo(link.sdo));

  // *********************************
  // clock, watchdog and conversion length
  // *********************************
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // a hung handshake ends the run as a mismatch
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      end_sim();
    end
  end

  // length of the current run of convert cycles, seen mid-cycle
  always @(negedge clk_sys) begin
    conv_run <= (state === CCST_CONVERT && rst_b === 1'b1) ? conv_run + 1 : 0;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // waits for the end of the running conversion and judges its length
  task automatic meas_conv(input int exp_cyc);
    @(negedge clk_sys);
    while (state !== CCST_SLEEP) @(negedge clk_sys);
    chk_flag(conv_run >= exp_cyc - 1 && conv_run <= exp_cyc + 1, 1'b1);
  endtask

  // one readout; mid 1 flips the select level, mid 2 starts the oscillator,
  // both a hundred cycles into the shift so the change lands mid-word
  task automatic read_word(input logic use_ext, input int mid);
    int k;
    k = 0;
    @(posedge clk_sys);
    start <= 1'b1;
    ext_sck <= use_ext;
    @(posedge clk_sys);
    start <= 1'b0;
    @(negedge clk_sys);
    chk_flag(busy, 1'b1);
    while (rd_valid !== 1'b1) begin
      @(negedge clk_sys);
      if (state === CCST_OUTPUT) k++;
      if (k == 100 && mid != 0) begin
        @(posedge clk_sys);
        if (mid == 1) sel_level <= ~sel_level;
        if (mid == 2) osc_en <= 1'b1;
        k++;
      end
    end
  endtask

  // *********************************
  // main sequence
  // *********************************
  initial begin
    rst_b = 1'b0;
    sel_level = 1'b0;
    osc_en = 1'b0;
    osc_half = 16'h0014;
    start = 1'b0;
    ext_sck = 1'b0;
    sample = VA;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    meas_conv(C60);
    chk_flag(notch_50, 1'b0);
    chk_flag(ext_clk_mode, 1'b0);
    read_word(1'b0, 0);
    chk_word(rd_word, {2'h0, VA});
    @(posedge clk_sys);
    sel_level <= 1'b1;
    sample <= VB;
    // a rising select level is held back one detection window before use
    repeat (250) @(negedge clk_sys);
    chk_flag(notch_50, 1'b1);
    read_word(1'b1, 0);
    chk_word(rd_word, {2'h0, VB});
    chk_flag(int_sck_mode, 1'b0);
    chk_word({2'h0, avg_result}, {2'h0, SUM[30:1]});
    @(posedge clk_sys);
    sample <= VC;
    meas_conv(C50);
    read_word(1'b0, 1);
    chk_word(rd_word, {2'h0, VC});
    @(posedge clk_sys);
    sample <= VD;
    meas_conv(C60);
    read_word(1'b0, 2);
    chk_word(rd_word, {2'h0, VD});
    chk_flag(ext_clk_mode, 1'b1);
    @(posedge clk_sys);
    osc_en <= 1'b0;
    sample <= VE;
    repeat (400) @(negedge clk_sys);
    chk_flag(ext_clk_mode, 1'b0);
    read_word(1'b1, 0);
    chk_word(rd_word, {2'h0, VE});
    @(posedge clk_sys);
    sample <= VF;
    meas_conv(C60);
    // clock source changes while asleep must leave the stored word intact
    @(posedge clk_sys);
    osc_half <= 16'h0096;
    osc_en <= 1'b1;
    repeat (1000) @(negedge clk_sys);
    chk_flag(ext_clk_mode, 1'b0);
    @(posedge clk_sys);
    osc_half <= 16'h0014;
    repeat (300) @(negedge clk_sys);
    chk_flag(ext_clk_mode, 1'b1);
    @(posedge clk_sys);
    osc_en <= 1'b0;
    repeat (400) @(negedge clk_sys);
    chk_flag(ext_clk_mode, 1'b0);
    read_word(1'b0, 0);
    chk_word(rd_word, {2'h0, VF});
    end_sim();
  end
endmodule
